//--- rtl/srcc_pkg.sv
// constants, field layouts and enumerations of the reference clock control
// assumes one 100 MHz reference clock domain and a byte-wide register port
package srcc_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_OP_CTRL = 7'h01;
    localparam logic [6:0] ADDR_FRF_MSB = 7'h07;
    localparam logic [6:0] ADDR_FRF_MID = 7'h08;
    localparam logic [6:0] ADDR_FRF_LSB = 7'h09;
    localparam logic [6:0] ADDR_IO_MAP2 = 7'h26;
    localparam logic [6:0] ADDR_STATUS = 7'h27;
    localparam logic [6:0] ADDR_EXT_CLK = 7'h59;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned EXT_CLK_BIT = 4;
    localparam int unsigned OP_MODE_LSB = 2;
    localparam int unsigned SEQ_OFF_BIT = 7;
    localparam int unsigned REFERENCE_CLOCK_OUTPUT_SEL_LSB = 0;
    localparam logic [2:0] REFERENCE_CLOCK_OUTPUT_SEL_OFF_MIN = 3'h6;
    localparam int unsigned STAT_OSC_BIT = 7;
    localparam int unsigned STAT_LOCK_BIT = 4;
    // synthesizer fractional bits
    localparam int unsigned SYNTH_FRAC_BITS = 19;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_OP_CTRL = 8'h04;
    localparam logic [7:0] RST_IO_MAP2 = 8'h00;
    localparam logic [7:0] RST_EXT_CLK = 8'h00;
    localparam logic [7:0] RST_FRF_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SRCC_MODE_SLEEP = 3'h0,
        SRCC_MODE_STANDBY = 3'h1,
        SRCC_MODE_FS = 3'h2,
        SRCC_MODE_TX = 3'h3,
        SRCC_MODE_RX = 3'h4
    } srcc_mode_e;

    typedef enum logic [1:0] {
        SRCC_SEQ_IDLE = 2'h0,
        SRCC_SEQ_WAIT_OSC = 2'h1,
        SRCC_SEQ_WAIT_LOCK = 2'h3,
        SRCC_SEQ_RUN = 2'h2
    } srcc_seq_e;

endpackage

//--- rtl/srcc_reference_clock_output_div.sv
// divider for the clock output pin
// assumes enable and select come from logic on the same clock
`timescale 1ns/1ns
module srcc_reference_clock_output_div #(
    parameter int unsigned CNT_W = 6
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic en_i,
    input wire logic [2:0] sel_i,
    output logic clk_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic out;
    } srcc_div_s;

    srcc_div_s st_r;
    srcc_div_s st_nxt;

    // free counter; bit n gives the reference divided by 2^(n+1)
    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt = st_r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        if (en_i && (32'(sel_i) < CNT_W)) begin
            st_nxt.out = st_nxt.cnt[sel_i];
        end else begin
            st_nxt.out = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign clk_o = st_r.out;

endmodule

//--- rtl/srcc_top.sv
// reference clock, carrier word, sequencer hand-offs and lock indication
// assumes oscillator and lock inputs come from the analog side, unsynchronised
`timescale 1ns/1ns
module srcc_top (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    input wire logic osc_stable_i,
    input wire logic pll_lock_i,
    output logic [23:0] synth_word_o,
    output logic ext_clk_sel_o,
    output logic pll_enable_o,
    output logic rx_enable_o,
    output logic tx_enable_o,
    output logic coarse_cal_o,
    output logic fine_cal_o,
    output logic lock_ind_o,
    output logic general_io_five_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] frf_msb;
        logic [7:0] frf_mid;
        logic [7:0] frf_lsb;
        logic [23:0] word;
        logic [7:0] op_ctrl;
        logic [7:0] io_map2;
        logic [7:0] ext_clk;
        logic osc_s1;
        logic osc_s2;
        logic lock_s1;
        logic lock_s2;
        srcc_pkg::srcc_seq_e seq;
        logic pll;
        logic rx;
        logic tx;
        logic coarse;
        logic coarse_done;
        logic fine;
        logic lock_out;
        logic [7:0] rdata;
    } srcc_state_s;

    srcc_state_s st_r;
    srcc_state_s st_nxt;

    function automatic logic [2:0] mode_of(input logic [7:0] ctrl);
        mode_of = ctrl[srcc_pkg::OP_MODE_LSB +: 3];
    endfunction

    function automatic logic is_active(input logic [2:0] m);
        is_active = (m == srcc_pkg::SRCC_MODE_FS) || (m == srcc_pkg::SRCC_MODE_TX) ||
                    (m == srcc_pkg::SRCC_MODE_RX);
    endfunction

    logic active;
    logic seq_on;
    logic [2:0] mode;
    logic [2:0] clk_sel;
    logic clk_en;

    assign mode = mode_of(st_r.op_ctrl);
    assign active = is_active(mode);
    assign seq_on = !st_r.op_ctrl[srcc_pkg::SEQ_OFF_BIT];
    assign clk_sel = st_r.io_map2[srcc_pkg::REFERENCE_CLOCK_OUTPUT_SEL_LSB +: 3];
    // silent until stable, stopped in sleep, off by select
    assign clk_en = st_r.osc_s2 && (mode != srcc_pkg::SRCC_MODE_SLEEP) &&
                    (clk_sel < srcc_pkg::REFERENCE_CLOCK_OUTPUT_SEL_OFF_MIN);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.osc_s1 = osc_stable_i;
        st_nxt.osc_s2 = st_r.osc_s1;
        st_nxt.lock_s1 = pll_lock_i;
        st_nxt.lock_s2 = st_r.lock_s1;
        // lock follows the synchronised detector level
        st_nxt.lock_out = st_r.lock_s2;
        // register writes
        if (reg_we_i) begin
            unique case (reg_addr_i)
                srcc_pkg::ADDR_OP_CTRL: st_nxt.op_ctrl = reg_wdata_i;
                srcc_pkg::ADDR_FRF_MSB: st_nxt.frf_msb = reg_wdata_i;
                srcc_pkg::ADDR_FRF_MID: st_nxt.frf_mid = reg_wdata_i;
                srcc_pkg::ADDR_FRF_LSB: begin
                    st_nxt.frf_lsb = reg_wdata_i;
                    st_nxt.word = {st_r.frf_msb, st_r.frf_mid, reg_wdata_i};
                end
                srcc_pkg::ADDR_IO_MAP2: st_nxt.io_map2 = reg_wdata_i;
                srcc_pkg::ADDR_EXT_CLK: st_nxt.ext_clk = reg_wdata_i;
                default: ;
            endcase
        end
        // register reads
        if (reg_re_i) begin
            unique case (reg_addr_i)
                srcc_pkg::ADDR_OP_CTRL: st_nxt.rdata = st_r.op_ctrl;
                srcc_pkg::ADDR_FRF_MSB: st_nxt.rdata = st_r.frf_msb;
                srcc_pkg::ADDR_FRF_MID: st_nxt.rdata = st_r.frf_mid;
                srcc_pkg::ADDR_FRF_LSB: st_nxt.rdata = st_r.frf_lsb;
                srcc_pkg::ADDR_IO_MAP2: st_nxt.rdata = st_r.io_map2;
                srcc_pkg::ADDR_STATUS: st_nxt.rdata = {st_r.osc_s2, 2'h0, st_r.lock_out, 2'h0, st_r.seq};
                srcc_pkg::ADDR_EXT_CLK: st_nxt.rdata = st_r.ext_clk;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        // sequencer
        unique case (st_r.seq)
            srcc_pkg::SRCC_SEQ_IDLE: begin
                if (active) begin
                    st_nxt.seq = srcc_pkg::SRCC_SEQ_WAIT_OSC;
                end
            end
            srcc_pkg::SRCC_SEQ_WAIT_OSC: begin
                if (!active) begin
                    st_nxt.seq = srcc_pkg::SRCC_SEQ_IDLE;
                end else if (st_r.osc_s2) begin
                    st_nxt.seq = srcc_pkg::SRCC_SEQ_WAIT_LOCK;
                end
            end
            srcc_pkg::SRCC_SEQ_WAIT_LOCK: begin
                if (!active) begin
                    st_nxt.seq = srcc_pkg::SRCC_SEQ_IDLE;
                end else if (st_r.lock_s2) begin
                    st_nxt.seq = srcc_pkg::SRCC_SEQ_RUN;
                end
            end
            srcc_pkg::SRCC_SEQ_RUN: begin
                // lock drops during transmit do not abort the run
                if (!active) begin
                    st_nxt.seq = srcc_pkg::SRCC_SEQ_IDLE;
                end
            end
        endcase
        if (seq_on) begin
            st_nxt.pll = (st_nxt.seq == srcc_pkg::SRCC_SEQ_WAIT_LOCK) ||
                         (st_nxt.seq == srcc_pkg::SRCC_SEQ_RUN);
            st_nxt.rx = (st_nxt.seq == srcc_pkg::SRCC_SEQ_RUN) && (mode == srcc_pkg::SRCC_MODE_RX);
            st_nxt.tx = (st_nxt.seq == srcc_pkg::SRCC_SEQ_RUN) && (mode == srcc_pkg::SRCC_MODE_TX);
        end else begin
            // host times the hand-off itself
            st_nxt.pll = active;
            st_nxt.rx = (mode == srcc_pkg::SRCC_MODE_RX);
            st_nxt.tx = (mode == srcc_pkg::SRCC_MODE_TX);
        end
        // calibration strobes
        st_nxt.coarse = !st_r.coarse_done;
        st_nxt.coarse_done = 1'b1;
        st_nxt.fine = st_nxt.pll && !st_r.pll;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_r <= '0;
            st_r.op_ctrl <= srcc_pkg::RST_OP_CTRL;
            st_r.io_map2 <= srcc_pkg::RST_IO_MAP2;
            st_r.ext_clk <= srcc_pkg::RST_EXT_CLK;
            st_r.frf_msb <= srcc_pkg::RST_FRF_BYTE;
            st_r.frf_mid <= srcc_pkg::RST_FRF_BYTE;
            st_r.frf_lsb <= srcc_pkg::RST_FRF_BYTE;
            st_r.seq <= srcc_pkg::SRCC_SEQ_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // clock output
    // ------------------------------------------------------------------
    srcc_reference_clock_output_div #(
        .CNT_W(6)
    ) u_div (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .en_i(clk_en),
        .sel_i(clk_sel),
        .clk_o(general_io_five_o)
    );

    assign reg_rdata_o = st_r.rdata;
    assign synth_word_o = st_r.word;
    assign ext_clk_sel_o = st_r.ext_clk[srcc_pkg::EXT_CLK_BIT];
    assign pll_enable_o = st_r.pll;
    assign rx_enable_o = st_r.rx;
    assign tx_enable_o = st_r.tx;
    assign coarse_cal_o = st_r.coarse;
    assign fine_cal_o = st_r.fine;
    assign lock_ind_o = st_r.lock_out;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_lsb_write;
        reg_we_i && (reg_addr_i == srcc_pkg::ADDR_FRF_LSB);
    endsequence

    sequence s_upper_write;
        reg_we_i && ((reg_addr_i == srcc_pkg::ADDR_FRF_MSB) || (reg_addr_i == srcc_pkg::ADDR_FRF_MID));
    endsequence

    a_lsb_commits_word: assert property (s_lsb_write |=>
        synth_word_o == {$past(st_r.frf_msb), $past(st_r.frf_mid), $past(reg_wdata_i)})
        else $error("carrier word not committed on low byte write");

    a_upper_only_staged: assert property (s_upper_write |=> $stable(synth_word_o))
        else $error("carrier word changed on upper byte write");

    a_byte_readback: assert property (s_upper_write ##1 !reg_we_i ##1 (reg_re_i && !reg_we_i &&
        (reg_addr_i == $past(reg_addr_i, 2))) |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("carrier byte readback differs from written value");

    a_msb_position: assert property (s_lsb_write |=> synth_word_o[23:16] == $past(st_r.frf_msb))
        else $error("high carrier byte not in top bits");

    a_pll_on_stable: assert property ((st_r.seq == srcc_pkg::SRCC_SEQ_WAIT_OSC) && active &&
        seq_on && st_r.osc_s2 |=> pll_enable_o)
        else $error("PLL not started on stable oscillator");

    a_reference_clock_output_silent: assert property (!st_r.osc_s2 |=> !general_io_five_o)
        else $error("clock output active before oscillator stable");

    a_ext_clk_sel: assert property (reg_we_i && (reg_addr_i == srcc_pkg::ADDR_EXT_CLK) |=>
        ext_clk_sel_o == $past(reg_wdata_i[srcc_pkg::EXT_CLK_BIT]))
        else $error("external clock select not taken");

    a_sleep_stops_clk: assert property ((mode == srcc_pkg::SRCC_MODE_SLEEP) |=> !general_io_five_o)
        else $error("clock output running in sleep");

    a_coarse_once: assert property (coarse_cal_o |=> !coarse_cal_o [*8])
        else $error("coarse calibration repeated");

    a_fine_on_start: assert property ($rose(pll_enable_o) |-> fine_cal_o)
        else $error("fine calibration missing at PLL start");

    a_no_rf_before_lock: assert property (seq_on && (st_r.seq == srcc_pkg::SRCC_SEQ_WAIT_LOCK) &&
        !st_r.lock_s2 |=> !rx_enable_o && !tx_enable_o)
        else $error("radio enabled before lock");

    a_lock_follows: assert property (!$past(srst_i, 3) |-> lock_ind_o == $past(pll_lock_i, 3))
        else $error("lock indication does not follow detector");

endmodule

//--- testbench/srcc_host_model.sv
// host microcontroller model driving the register port
// assumes inputs are applied on the falling edge of the reference clock
`timescale 1ns/1ns
module srcc_host_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [6:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_we_o,
    output logic reg_re_o
);
    // ------------------------------------------------------------------
    // register access tasks
    // ------------------------------------------------------------------
    initial begin
        reg_addr_o = 7'h00;
        reg_wdata_o = 8'h00;
        reg_we_o = 1'b0;
        reg_re_o = 1'b0;
    end

    // one-cycle write strobe; write data inverted after the strobe
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_we_o = 1'b1;
        @(negedge ref_clk_i);
        reg_we_o = 1'b0;
        reg_wdata_o = ~d;
    endtask

    // one-cycle read strobe, data taken one cycle later
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        reg_addr_o = a;
        reg_re_o = 1'b1;
        @(negedge ref_clk_i);
        reg_re_o = 1'b0;
        d = reg_rdata_i;
    endtask

    // clock output switched off when unused
    task automatic reference_clock_output_off();
        wr(7'h26, 8'h07);
    endtask

    // polls the status lock bit for up to 20 reads and reports whether it was seen set
    task automatic wait_lock(output logic ok);
        logic [7:0] d;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            rd(7'h27, d);
            ok = (d[4] === 1'b1);
        end
    endtask
endmodule

//--- testbench/srcc_top_tb.sv
// self-checking bench for the reference clock control
// assumes the host model drives registers and the bench drives analog inputs
`timescale 1ns/1ns
module srcc_top_tb;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic osc_stable_i = 1'b0;
    logic pll_lock_i = 1'b0;
    logic [6:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_we_i;
    logic reg_re_i;
    logic [7:0] reg_rdata_o;
    logic [23:0] synth_word_o;
    logic ext_clk_sel_o;
    logic pll_enable_o;
    logic rx_enable_o;
    logic tx_enable_o;
    logic coarse_cal_o;
    logic fine_cal_o;
    logic lock_ind_o;
    logic general_io_five_o;
    int n_errors = 0;
    int tests_run = 0;
    int n_coarse = 0;
    int n_fine = 0;
    logic [7:0] d;
    logic ok;
    int t;
    logic [6:0] row_a [5] = '{7'h07, 7'h08, 7'h10, 7'h59, 7'h26};
    logic [7:0] row_d [5] = '{8'haa, 8'hbb, 8'h55, 8'h10, 8'h05};
    logic [7:0] row_e [5] = '{8'haa, 8'hbb, 8'h00, 8'h10, 8'h05};

    always #5 ref_clk_i = ~ref_clk_i;

    srcc_top srcc_top_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .osc_stable_i(osc_stable_i), .pll_lock_i(pll_lock_i), .synth_word_o(synth_word_o),
        .ext_clk_sel_o(ext_clk_sel_o), .pll_enable_o(pll_enable_o), .rx_enable_o(rx_enable_o),
        .tx_enable_o(tx_enable_o), .coarse_cal_o(coarse_cal_o), .fine_cal_o(fine_cal_o),
        .lock_ind_o(lock_ind_o), .general_io_five_o(general_io_five_o));

    srcc_host_model srcc_host_model_i (.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_we_o(reg_we_i), .reg_re_o(reg_re_i));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (coarse_cal_o === 1'b1) begin
            n_coarse++;
        end
        if (fine_cal_o === 1'b1) begin
            n_fine++;
        end
    end

    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // counts clock output changes over 64 cycles
    task automatic toggles(output int n);
        logic last;
        n = 0;
        @(negedge ref_clk_i);
        last = general_io_five_o;
        repeat (64) begin
            @(negedge ref_clk_i);
            if (general_io_five_o !== last) begin
                n++;
            end
            last = general_io_five_o;
        end
    endtask

    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 12 && s !== 1'b1; i++) begin
            @(negedge ref_clk_i);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        n_errors++;
        conclude();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(negedge ref_clk_i);
        srst_i = 1'b0;
        toggles(t);
        chk("reference_clock_output before osc", t, 0);
        srcc_host_model_i.rd(7'h01, d);
        chk("op_ctrl reset", d, 8'h04);
        srcc_host_model_i.rd(7'h26, d);
        chk("io_map2 reset", d, 8'h00);
        chk("coarse pulses", n_coarse, 1);
        osc_stable_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        toggles(t);
        chk("reference_clock_output default", t, 64);
        $display("test reset done");
        for (int r = 0; r < 5; r++) begin
            srcc_host_model_i.wr(row_a[r], row_d[r]);
            srcc_host_model_i.rd(row_a[r], d);
            chk("reg readback", d, row_e[r]);
            chk("staged word", synth_word_o, 24'h000000);
        end
        chk("ext clock select", ext_clk_sel_o, 1'b1);
        $display("test rows done");
        srcc_host_model_i.wr(7'h09, 8'hcc);
        @(negedge ref_clk_i);
        chk("committed word", synth_word_o, 24'haabbcc);
        srcc_host_model_i.wr(7'h07, 8'h12);
        chk("word after msb", synth_word_o, 24'haabbcc);
        srcc_host_model_i.rd(7'h09, d);
        chk("lsb readback", d, 8'hcc);
        $display("test commit done");
        for (int s = 0; s < 8; s++) begin
            srcc_host_model_i.wr(7'h26, 8'(s));
            toggles(t);
            chk("reference_clock_output rate", (s < 6) ? (t >= (64 >> s) - 1 && t <= (64 >> s) + 1) : (t == 0), 1'b1);
        end
        srcc_host_model_i.wr(7'h26, 8'h00);
        srcc_host_model_i.wr(7'h01, 8'h00);
        toggles(t);
        chk("reference_clock_output in sleep", t, 0);
        srcc_host_model_i.reference_clock_output_off();
        $display("test clock output done");
        osc_stable_i = 1'b0;
        srcc_host_model_i.wr(7'h01, 8'h10);
        repeat (8) @(negedge ref_clk_i);
        chk("pll before osc", pll_enable_o, 1'b0);
        osc_stable_i = 1'b1;
        wait_hi(pll_enable_o);
        chk("pll after osc", pll_enable_o, 1'b1);
        chk("rx before lock", rx_enable_o, 1'b0);
        pll_lock_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        chk("lock ind early", lock_ind_o, 1'b0);
        @(negedge ref_clk_i);
        chk("lock ind", lock_ind_o, 1'b1);
        srcc_host_model_i.wait_lock(ok);
        wait_hi(rx_enable_o);
        chk("rx after lock", rx_enable_o, 1'b1);
        srcc_host_model_i.rd(7'h27, d);
        chk("status run", d & 8'h93, 8'h92);
        pll_lock_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        chk("lock ind low", lock_ind_o, 1'b0);
        chk("rx kept", rx_enable_o, 1'b1);
        srcc_host_model_i.wr(7'h01, 8'h04);
        @(negedge ref_clk_i);
        chk("pll off", {pll_enable_o, rx_enable_o}, 2'b00);
        pll_lock_i = 1'b1;
        srcc_host_model_i.wr(7'h01, 8'h0c);
        wait_hi(tx_enable_o);
        chk("tx after lock", {tx_enable_o, rx_enable_o}, 2'b10);
        chk("fine pulses", n_fine, 2);
        chk("coarse once", n_coarse, 1);
        srcc_host_model_i.wr(7'h01, 8'h90);
        @(negedge ref_clk_i);
        chk("host timed rx", {pll_enable_o, rx_enable_o, tx_enable_o}, 3'b110);
        $display("test sequencer done");
        conclude();
    end
endmodule
